// >>> sc_dram_ctrl.sv
// Host-side controller driving a static column DRAM through its pins
// Notes on behaviour
// RQ1: Device stores 262,144 four-bit words over four shared data pins.
// RQ2: Row nine bits on row strobe, then column nine bits on column strobe.
// RQ3: Row address stable by row strobe fall, column by column strobe fall.
// RQ4: Device address latches are transparent after the row-to-column address delay.
// RQ5: Write enable low starts write, high starts read; data ignored on reads.
// RQ6: Device captures data on later falling edge of write enable or column strobe.
// RQ7: Early write drops write enable before column strobe; delayed write after.
// RQ8: Device outputs stay high impedance until column strobe falls; same polarity.
// RQ9: Read data valid within row strobe access time, 70 ns.
// RQ10: Late column strobe: data valid within column strobe access time, 25 ns.
// RQ11: Late column address: data valid within column address access, 43 ns.
// RQ12: Late output enable: data timed from output enable fall.
// RQ13: Read data held until column strobe or output enable rises.
// RQ14: Early write keeps device outputs high impedance whole cycle.
// RQ15: With row strobe low, successive column accesses run in the open row.
// RQ16: Successive column accesses spaced at least 48 ns apart.
// RQ17: All 512 rows refreshed within every 8.2 ms.
// RQ18: Device supports row-only, column-before-row and hidden refresh.
// RQ19: Column strobe high at least 15 ns before column-before-row refresh.
// RQ20: Row-only refresh latches row on row strobe fall, data pins floating.
// RQ21: After power-up wait 200 us strobes high, then eight refresh cycles.
// RQ22: In static column mode only the first access needs a row address.
// RQ23: Column-before-row refresh takes its row from the device's counter.
`include "sc_dram_regs.svh"
module sc_dram_ctrl #(
  parameter int PWRUP_CYC = `CYC_MIN(`POWER_UP_NS),
  parameter int RAS_MAX_CYC = `CYC_MAX(`RAS_MAX_NS)
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire sc_dram_pkg::mem_req_t req,
  output logic rd_valid,
  output logic [3:0] rd_data,
  output logic init_done,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic oe_n,
  output logic [8:0] mux_address_pins,
  input wire logic [3:0] data_io_pins_in,
  output logic [3:0] data_io_pins_out,
  output logic [3:0] data_io_pins_oe
);
  import sc_dram_pkg::*;

  // ************************************************************
  // Address split helpers
  // ************************************************************
  function automatic logic [8:0] row_of(input logic [17:0] a);
    return a[`ROW_MSB:`ROW_LSB];
  endfunction

  function automatic logic [8:0] col_of(input logic [17:0] a);
    return a[`COL_MSB:`COL_LSB];
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  ctl_q_t s_q;
  ctl_q_t s_d;
  logic tick;
  logic cbr_done;
  logic row_hit;
  logic ras_old;
  logic must_close;

  sc_refresh_timer u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tick(tick)
  );

  assign row_hit = s_q.row_open && (row_of(req.addr) == s_q.row);
  // Leave margin so a running access never pushes the row past its limit
  assign ras_old = s_q.ras_cnt >= 14'(RAS_MAX_CYC - `RAS_GUARD_CYC);
  // Refresh owed, row too old or a request to another row forces the open row shut before more work
  assign must_close = s_q.row_open && ((s_q.owed != 4'h0) || ras_old ||
                      (req_valid && !row_hit));
  assign req_ready = (s_q.st == ST_IDLE) && (s_q.owed == 4'h0) &&
                     (!s_q.row_open || (row_hit && !ras_old));

  always_comb begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + 16'h0001;
    s_d.rd_valid = 1'b0;
    cbr_done = 1'b0;
    if (!s_q.ras_n && s_q.ras_cnt != 14'h3FFF) begin
      s_d.ras_cnt = s_q.ras_cnt + 14'h0001;
    end
    unique case (s_q.st)
      ST_PWRUP: begin
        // Both strobes parked high through the power-up pause
        if (s_q.cnt >= 16'(PWRUP_CYC - 1)) begin  // RQ21
          s_d.st = ST_PRECHG;
          s_d.cnt = 16'h0000;
        end
      end
      ST_PRECHG: begin
        // Precharge also covers the column strobe high time before refresh
        if (s_q.cnt >= 16'(`RP_CYC - 1) && s_q.cnt >= 16'(`CPN_CYC - 1)) begin  // RQ19
          s_d.cnt = 16'h0000;
          if (s_q.init_left != 4'h0 || s_q.owed != 4'h0) begin
            s_d.st = ST_CBR_CAS;
            s_d.cas_n = 1'b0;
          end else begin
            s_d.st = ST_IDLE;
          end
        end
      end
      ST_CBR_CAS: begin
        // Column strobe leads; the device supplies the refresh row itself
        s_d.st = ST_CBR_RAS;  // RQ23
        s_d.ras_n = 1'b0;
        s_d.ras_cnt = 14'h0000;
        s_d.cnt = 16'h0000;
      end
      ST_CBR_RAS: begin
        if (s_q.cnt >= 16'(`RAS_MIN_CYC - 1) && s_q.cnt >= 16'(`CHR_CYC - 1)) begin
          s_d.st = ST_PRECHG;
          s_d.ras_n = 1'b1;
          s_d.cas_n = 1'b1;
          s_d.cnt = 16'h0000;
          if (s_q.init_left != 4'h0) begin
            s_d.init_left = s_q.init_left - 4'h1;  // RQ21
          end else begin
            cbr_done = 1'b1;  // RQ17
          end
        end
      end
      ST_IDLE: begin
        s_d.cnt = 16'h0000;
        if (must_close) begin
          if (s_q.ras_cnt >= 14'(`RAS_MIN_CYC)) begin
            s_d.st = ST_PRECHG;
            s_d.ras_n = 1'b1;
            s_d.row_open = 1'b0;
          end
        end else if (!s_q.row_open && s_q.owed != 4'h0) begin
          // Refresh falling due with no row open would otherwise stall here
          s_d.st = ST_PRECHG;  // RQ17
        end else if (req_valid && req_ready) begin
          s_d.cur_write = req.write;
          s_d.dq_out = req.wdata;
          if (row_hit) begin
            // Open row: column address only, no new row strobe
            s_d.st = ST_COL;  // RQ22 RQ15
            s_d.addr = col_of(req.addr);
            s_d.we_n = !req.write;  // RQ5
            s_d.oe_n = req.write;
            s_d.dq_oe = req.write;
          end else begin
            s_d.st = ST_ROW;  // RQ2
            s_d.addr = row_of(req.addr);  // RQ3
            s_d.row = row_of(req.addr);
            s_d.col = col_of(req.addr);
            s_d.ras_n = 1'b0;
            s_d.ras_cnt = 14'h0000;
            s_d.row_open = 1'b1;
          end
        end
      end
      ST_ROW: begin
        // Row address held past its hold time before switching to column
        if (s_q.cnt >= 16'(`RAH_CYC - 1)) begin
          s_d.st = ST_COL;
          s_d.cnt = 16'h0000;
          s_d.addr = s_q.col;  // RQ2
          s_d.we_n = !s_q.cur_write;  // RQ5 RQ7
          s_d.oe_n = s_q.cur_write;
          s_d.dq_oe = s_q.cur_write;
        end
      end
      ST_COL: begin
        // Column address and write enable were set a cycle before this fall
        if (s_q.cnt == 16'h0000) begin
          s_d.cas_n = 1'b0;  // RQ3 RQ7
        end
        // Sampling one access time after the column address also covers
        // the row and column strobe access times on this schedule
        if (s_q.cnt == 16'(`AA_CYC)) begin
          s_d.st = ST_CAS_HI;
          s_d.cnt = 16'h0000;
          s_d.cas_n = 1'b1;
          s_d.we_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.dq_oe = 1'b0;
          if (!s_q.cur_write) begin
            s_d.rd_valid = 1'b1;  // RQ11 RQ9 RQ10
            s_d.rd_data = data_io_pins_in;
          end
        end
      end
      ST_CAS_HI: begin
        // Column precharge closes out an access spaced well past 48 ns
        if (s_q.cnt >= 16'(`CP_CYC - 1)) begin  // RQ16
          s_d.st = ST_IDLE;
          s_d.cnt = 16'h0000;
        end
      end
      default: begin
        s_d.st = ST_PRECHG;
        s_d.ras_n = 1'b1;
        s_d.cas_n = 1'b1;
      end
    endcase
    // A tick in the same cycle as a finished refresh keeps its count
    s_d.owed = s_q.owed;
    if (tick && !cbr_done && s_q.owed != 4'(`OWED_MAX)) begin
      s_d.owed = s_q.owed + 4'h1;  // RQ17
    end else if (cbr_done && !tick) begin
      s_d.owed = s_q.owed - 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{st: ST_PWRUP, cnt: 16'h0000, ras_cnt: 14'h0000,
               init_left: 4'(`INIT_CYCLES), owed: 4'h0, row_open: 1'b0,
               row: 9'h000, col: 9'h000, cur_write: 1'b0, ras_n: 1'b1, cas_n: 1'b1,
               we_n: 1'b1, oe_n: 1'b1, addr: 9'h000, dq_out: 4'h0,
               dq_oe: 1'b0, rd_valid: 1'b0, rd_data: 4'h0};
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Pin and user outputs
  // ************************************************************
  assign ras_n = s_q.ras_n;
  assign cas_n = s_q.cas_n;
  assign we_n = s_q.we_n;
  assign oe_n = s_q.oe_n;
  assign mux_address_pins = s_q.addr;
  assign data_io_pins_out = s_q.dq_out;
  assign data_io_pins_oe = {4{s_q.dq_oe}};
  assign rd_valid = s_q.rd_valid;
  assign rd_data = s_q.rd_data;
  assign init_done = (s_q.init_left == 4'h0);
endmodule

// >>> sc_dram_ctrl_chk.sv
// Pin-level assertions for the static column DRAM controller
module sc_dram_ctrl_chk #(
  parameter int PWRUP_CYC = 25000
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire sc_dram_pkg::mem_req_t req,
  input wire logic rd_valid,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [8:0] mux_address_pins,
  input wire logic [3:0] data_io_pins_oe
);
  import sc_dram_pkg::*;
  logic [15:0] up_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_q <= 16'h0000;
    end else if (up_q != 16'hFFFF) begin
      up_q <= up_q + 16'h0001;
    end
  end
  AST_PWRUP_IDLE: assert property ((up_q < PWRUP_CYC) |-> ras_n && cas_n)
    else $error("strobe moved in power-up pause");
  AST_CBR_ORDER: assert property ($fell(cas_n) && ras_n |=> $fell(ras_n))
    else $error("column strobe not followed by row strobe");
  AST_CBR_PRECHG: assert property ($fell(cas_n) && ras_n |-> $past(cas_n, 2))
    else $error("column precharge too short");
  AST_EARLY_WE: assert property ($fell(we_n) |-> cas_n)
    else $error("write enable fell after column strobe");
  AST_WR_DRIVEN: assert property ($fell(cas_n) && !ras_n && !we_n |-> &data_io_pins_oe)
    else $error("write data not driven at column strobe");
  AST_RD_NO_DRIVE: assert property (!oe_n |-> data_io_pins_oe == 4'h0)
    else $error("data pins driven during read");
  AST_ROW_HOLD: assert property ($fell(ras_n) && cas_n |=> $stable(mux_address_pins))
    else $error("row address changed too soon");
  AST_COL_STABLE: assert property ($fell(cas_n) && !ras_n |-> $stable(mux_address_pins))
    else $error("column address not settled");
  AST_COL_SPACING: assert property ($fell(cas_n) |=> (!$fell(cas_n)) [*5])
    else $error("column accesses too close");
  AST_RD_LATENCY: assert property (req_valid && req_ready && !req.write
      |-> ##[7:12] rd_valid)
    else $error("read answer late");
  AST_RD_END: assert property (rd_valid |-> $rose(cas_n) && we_n)
    else $error("read ended without column strobe release");
  cover property ($fell(cas_n) && ras_n);
  cover property (rd_valid);
  cover property ($fell(we_n));
endmodule
bind sc_dram_ctrl sc_dram_ctrl_chk #(.PWRUP_CYC(PWRUP_CYC)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
  .req(req), .rd_valid(rd_valid), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
  .mux_address_pins(mux_address_pins), .data_io_pins_oe(data_io_pins_oe));

// >>> sc_dram_model.sv
// Behavioural static column DRAM seen from its pins
module sc_dram_model (
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [8:0] addr,
  input wire logic [3:0] dq_wr,
  output logic [3:0] dq_in,
  output int unsigned cbr_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mem [logic [17:0]];
  logic [8:0] row_q;
  logic [3:0] last_q = 4'h0;
  logic ready_q = 1'b0;
  initial cbr_count = 0;
  always @(negedge ras_n) begin
    // Sample after the pins settle; the row address is held for cycles
    #1;
    if (cas_n) row_q = addr;
    else cbr_count++;
  end
  // Column taken live from the pins: the latch flows through
  always @(negedge cas_n or negedge we_n) begin
    if (!ras_n && !cas_n && !we_n) mem[{row_q, addr}] = dq_wr;
  end
  always @(negedge cas_n) begin
    ready_q = 1'b0;
    if (!ras_n && we_n) #25 ready_q = !cas_n;
  end
  always @(posedge cas_n) ready_q = 1'b0;
  // Released pins show the inverse of the last value so a stale sample cannot pass
  always @(ready_q or oe_n or we_n or cas_n or addr or row_q) begin
    if (ready_q && !oe_n && we_n && !cas_n && mem.exists({row_q, addr})) begin
      dq_in = mem[{row_q, addr}];
      last_q = dq_in;
    end else dq_in = ~last_q;
  end
endmodule

// >>> sc_dram_pkg.sv
// Types shared by the static column DRAM controller
package sc_dram_pkg;

  typedef enum logic [3:0] {
    ST_PWRUP,
    ST_PRECHG,
    ST_CBR_CAS,
    ST_CBR_RAS,
    ST_IDLE,
    ST_ROW,
    ST_COL,
    ST_CAS_HI
  } ctl_state_t;

  typedef struct packed {
    logic write;
    logic [17:0] addr;
    logic [3:0] wdata;
  } mem_req_t;

  typedef struct packed {
    ctl_state_t st;
    logic [15:0] cnt;
    logic [13:0] ras_cnt;
    logic [3:0] init_left;
    logic [3:0] owed;
    logic row_open;
    logic [8:0] row;
    logic [8:0] col;
    logic cur_write;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic oe_n;
    logic [8:0] addr;
    logic [3:0] dq_out;
    logic dq_oe;
    logic rd_valid;
    logic [3:0] rd_data;
  } ctl_q_t;

endpackage

// >>> sc_dram_regs.svh
// Timing and field constants for the static column DRAM controller
`ifndef SC_DRAM_REGS_SVH
`define SC_DRAM_REGS_SVH

// ************************************************************
// Clock and conversion
// ************************************************************
`define CLK_NS 8
`define CYC_MIN(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define CYC_MAX(ns) ((ns) / `CLK_NS)

// ************************************************************
// Address layout
// ************************************************************
`define ADDR_W 18
`define HALF_W 9
`define DATA_W 4
`define ROW_LSB 9
`define ROW_MSB 17
`define COL_LSB 0
`define COL_MSB 8

// ************************************************************
// Device timing in ns and derived counts
// ************************************************************
`define ROW_ADDR_HOLD_NS 10
`define ROW_STROBE_ACCESS_NS 70
`define COLUMN_ADDRESS_ACCESS_NS 43
`define COLUMN_STROBE_ACCESS_NS 25
`define COLUMN_CYCLE_NS 48
`define CAS_PRECHARGE_NS 15
`define CBR_COLUMN_PRECHARGE_NS 15
`define CBR_CAS_HOLD_NS 15
`define RAS_PRECHARGE_NS 60
`define RAS_MIN_NS 70
`define RAS_MAX_NS 100000
`define POWER_UP_NS 200000
`define REFRESH_INTERVAL_NS 8200000
`define REFRESH_ROWS 512
`define INIT_CYCLES 8

`define RAH_CYC `CYC_MIN(`ROW_ADDR_HOLD_NS)
`define AA_CYC `CYC_MIN(`COLUMN_ADDRESS_ACCESS_NS)
`define CP_CYC `CYC_MIN(`CAS_PRECHARGE_NS)
`define RP_CYC `CYC_MIN(`RAS_PRECHARGE_NS)
`define RAS_MIN_CYC `CYC_MIN(`RAS_MIN_NS)
`define CHR_CYC `CYC_MIN(`CBR_CAS_HOLD_NS)
`define CPN_CYC `CYC_MIN(`CBR_COLUMN_PRECHARGE_NS)
`define ROW_TICK_CYC `CYC_MAX(`REFRESH_INTERVAL_NS / `REFRESH_ROWS)
`define RAS_GUARD_CYC 32
`define OWED_MAX 15

`endif

// >>> sc_refresh_timer.sv
// Per-row refresh pacing tick
`include "sc_dram_regs.svh"
module sc_refresh_timer (
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic tick
);
  logic [15:0] cnt_q;

  // One tick per row slot keeps all rows inside the refresh interval
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_q == 16'(`ROW_TICK_CYC - 1)) begin
      cnt_q <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

// >>> static_column_dram_interface_tb_top.sv
// Self-checking bench for the static column DRAM controller
module static_column_dram_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sc_dram_pkg::*;
  logic sys_clk, reset_n, req_valid, req_ready, rd_valid, init_done, ras_n, cas_n, we_n, oe_n;
  mem_req_t req;
  logic [3:0] rd_data, dq_in, dq_out, dq_oe, dq_wire;
  logic [8:0] addr_pins;
  logic [3:0] ref_mem [logic [17:0]];
  logic [3:0] exp_q [$];
  logic [17:0] a;
  int err_count = 0;
  int n_compared = 0;
  bit stalled = 1'b0;
  int i, n;
  int unsigned cbr_count, c0;
  assign dq_wire = (dq_oe & dq_out) | (~dq_oe & dq_in);
  sc_dram_ctrl #(.PWRUP_CYC(50), .RAS_MAX_CYC(64)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rd_valid(rd_valid),
    .rd_data(rd_data), .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .oe_n(oe_n), .mux_address_pins(addr_pins), .data_io_pins_in(dq_wire),
    .data_io_pins_out(dq_out), .data_io_pins_oe(dq_oe));
  sc_dram_model u_mem (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
    .addr(addr_pins), .dq_wr(dq_wire), .dq_in(dq_in), .cbr_count(cbr_count));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Request is held until the edge where ready is seen high
  task automatic access(input logic wr, input logic [17:0] ad, input logic [3:0] d);
    int k;
    if (stalled) return;
    @(posedge sys_clk);
    #1 req_valid = 1'b1;
    req = '{write: wr, addr: ad, wdata: d};
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 300);
    if (req_ready !== 1'b1) begin
      check(1'b0, 1'b1, "req_ready");
      stalled = 1'b1;
    end else begin
      @(posedge sys_clk);
      if (wr) ref_mem[ad] = d;
      else exp_q.push_back(ref_mem[ad]);
    end
    #1 req_valid = 1'b0;
  endtask
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0, "unexpected read");
      else check(rd_data, exp_q.pop_front(), "rd_data");
    end
  end
  initial begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    void'($urandom(32'h1ccc5a3d));
    repeat (16) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    for (n = 0; n < 2000 && init_done !== 1'b1; n++) @(posedge sys_clk);
    check(init_done, 1'b1, "init_done");
    check(cbr_count, 8, "init refreshes");
    $display("init test done");
    // ************************************************************
    // Open-row bursts, then random rows with boundary addresses
    // ************************************************************
    for (i = 0; i < 16; i++) access(i < 8, {9'h1FF, 9'((i % 8) * 73)}, 4'(i ^ 5));
    access(1'b1, 18'h00000, 4'hA);
    access(1'b1, 18'h3FFFF, 4'h5);
    for (i = 0; i < 40; i++) begin
      a = 18'($urandom) & 18'h301FF;
      access(($urandom_range(1) == 0) || !ref_mem.exists(a), a, 4'($urandom));
    end
    $display("access test done");
    c0 = cbr_count;
    repeat (4500) @(posedge sys_clk);
    check(cbr_count >= c0 + 2, 1'b1, "periodic refresh");
    foreach (ref_mem[k]) access(1'b0, k, 4'h0);
    for (n = 0; n < 50 && exp_q.size() > 0; n++) @(posedge sys_clk);
    check(exp_q.size(), 0, "pending reads");
    $display("refresh test done");
    test_done();
  end
endmodule
